// file: hw/pwd_regs.svh
`ifndef PWD_REGS_SVH
`define PWD_REGS_SVH

// register addresses on the serial control bus
`define PWD_ADDR_PP_A 8'h5a
`define PWD_ADDR_OD 8'h5b
`define PWD_ADDR_PP_B 8'h5c
`define PWD_CTL_RESET 8'h00

// open-drain control byte fields
`define PWD_OD_EN_BIT 7
`define PWD_OD_FREQ_LSB 4
`define PWD_OD_DUTY_LSB 0
`define PWD_OD_DUTY_FULL 4'hf
`define PWD_OD_STEPS 16

// push-pull control byte fields
`define PWD_PP_MODE_BIT 7
`define PWD_PP_RANGE_BIT 6
`define PWD_PP_ON_LSB 3
`define PWD_PP_OFF_LSB 0
`define PWD_SET_ALWAYS_ON 7'h7f

// time base
`define PWD_CLK_HZ 10000000
`define PWD_TICK_US 1
`define PWD_TICK_CYCLES (`PWD_CLK_HZ / 1000000 * `PWD_TICK_US)

// single-pulse mode: 250 Hz period, on-time S/32 ms
`define PWD_PERIOD_US 4000
`define PWD_SET_US_NUM 1000
`define PWD_SET_US_DEN 32

// open-drain frequencies in Hz, code 0 in the low bits
`define PWD_OD_FREQ_HZ {15'd750, 15'd1500, 15'd2300, 15'd3000, 15'd4500, 15'd6700, 15'd11700, 15'd23400}

// timed mode tables in microseconds, code 0 in the low bits
`define PWD_R0_ON_US {18'd244, 18'd214, 18'd183, 18'd153, 18'd122, 18'd92, 18'd61, 18'd31}
`define PWD_R0_OFF_US {18'd5000, 18'd4000, 18'd2990, 18'd2500, 18'd2010, 18'd1500, 18'd1010, 18'd490}
`define PWD_R1_ON_US {18'd60000, 18'd50000, 18'd40000, 18'd30000, 18'd20000, 18'd15000, 18'd10000, 18'd5000}
`define PWD_R1_OFF_US {18'd180000, 18'd160000, 18'd140000, 18'd120000, 18'd100000, 18'd80000, 18'd60000, 18'd40000}

`endif

// file: hw/pwd_pkg.sv
package pwd_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pwd_reg_req_s;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] act;
		logic [17:0] cnt;
		logic out;
	} pwd_pp_s;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] act;
		logic [9:0] slot_cnt;
		logic [3:0] slot;
		logic oe;
	} pwd_od_s;

	typedef struct packed {
		logic [11:0] tick_cnt;
		logic tick;
		pwd_pp_s [1:0] pp;
		pwd_od_s od;
		logic [7:0] rdata;
	} pwd_state_s;

endpackage : pwd_pkg

// file: hw/pwd_pulse_drivers.sv
// Notes on behaviour
// - open-drain output toggles only while enabled
// - open-drain byte: enable, frequency, duty fields
// - eight frequency codes from 23.4 to 0.75 kHz
// - duty is (n+1)/16, code 15 always active
// - two identical independent push-pull outputs
// - push-pull bytes reset to zero
// - single-pulse mode: one pulse per 250 Hz
// - on-time S/32 ms, 127 means always on
// - timed mode: range, on code, off code
// - short range on/off time tables
// - long range on/off time tables
`include "pwd_regs.svh"

module pwd_pulse_drivers
	import pwd_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `PWD_TICK_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// register access from the serial bus engine
	input wire pwd_reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	// open-drain pin, oe high while sinking
	output logic pulse_drv_o,
	output logic pulse_drv_oe,
	// push-pull pins
	output logic push_pull_out_a,
	output logic push_pull_out_b
);

	pwd_state_s s;
	pwd_state_s s_nxt;

	default clocking pwd_cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	function automatic logic [17:0] pwd_pick(input logic [143:0] tbl, input logic [2:0] code);
		return tbl[code * 18 +: 18];
	endfunction : pwd_pick

	// on-time in ticks for a push-pull setting
	function automatic logic [17:0] pwd_pp_on(input logic [7:0] c);
		if (!c[`PWD_PP_MODE_BIT])
			return 18'((32'(c[6:0]) * `PWD_SET_US_NUM) / `PWD_SET_US_DEN);
		else if (c[`PWD_PP_RANGE_BIT])
			return pwd_pick(`PWD_R1_ON_US, c[`PWD_PP_ON_LSB +: 3]);
		else
			return pwd_pick(`PWD_R0_ON_US, c[`PWD_PP_ON_LSB +: 3]);
	endfunction : pwd_pp_on

	// period length in ticks for a push-pull setting
	function automatic logic [17:0] pwd_pp_len(input logic [7:0] c);
		if (!c[`PWD_PP_MODE_BIT])
			return 18'(`PWD_PERIOD_US);
		else if (c[`PWD_PP_RANGE_BIT])
			return pwd_pp_on(c) + pwd_pick(`PWD_R1_OFF_US, c[`PWD_PP_OFF_LSB +: 3]);
		else
			return pwd_pp_on(c) + pwd_pick(`PWD_R0_OFF_US, c[`PWD_PP_OFF_LSB +: 3]);
	endfunction : pwd_pp_len

	// clock cycles per duty step, rounded to nearest
	function automatic logic [9:0] pwd_od_slot(input logic [2:0] f);
		logic [31:0] hz;
		hz = 32'(`PWD_OD_FREQ_HZ >> (f * 15)) & 32'h0000_7fff;
		return 10'((`PWD_CLK_HZ + hz * 8) / (hz * `PWD_OD_STEPS));
	endfunction : pwd_od_slot

	always_comb begin
		s_nxt = s;
		// common microsecond tick for every push-pull timer
		s_nxt.tick = (s.tick_cnt == 12'(TICK_CYCLES - 1));
		s_nxt.tick_cnt = s_nxt.tick ? 12'h000 : s.tick_cnt + 12'h001;

		if (reg_req.wr) begin
			unique case (reg_req.addr)
				`PWD_ADDR_PP_A: s_nxt.pp[0].cfg = reg_req.wdata;
				`PWD_ADDR_OD: s_nxt.od.cfg = reg_req.wdata;
				`PWD_ADDR_PP_B: s_nxt.pp[1].cfg = reg_req.wdata;
				default: ;
			endcase
		end
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`PWD_ADDR_PP_A: s_nxt.rdata = s.pp[0].cfg;
				`PWD_ADDR_OD: s_nxt.rdata = s.od.cfg;
				`PWD_ADDR_PP_B: s_nxt.rdata = s.pp[1].cfg;
				default: s_nxt.rdata = 8'h00;
			endcase
		end

		// both push-pull channels share one description
		for (int i = 0; i < 2; i++) begin
			if (s.tick) begin
				if (s.pp[i].cnt >= pwd_pp_len(s.pp[i].act) - 18'h00001) begin
					s_nxt.pp[i].cnt = 18'h00000;
					s_nxt.pp[i].act = s_nxt.pp[i].cfg;
				end else begin
					s_nxt.pp[i].cnt = s.pp[i].cnt + 18'h00001;
				end
			end
			s_nxt.pp[i].out = (s_nxt.pp[i].act == {1'b0, `PWD_SET_ALWAYS_ON})
				|| (s_nxt.pp[i].cnt < pwd_pp_on(s_nxt.pp[i].act));
		end

		// open-drain: sixteen duty steps per frequency period
		if (s.od.slot_cnt >= pwd_od_slot(s.od.act[`PWD_OD_FREQ_LSB +: 3]) - 10'h001) begin
			s_nxt.od.slot_cnt = 10'h000;
			s_nxt.od.slot = s.od.slot + 4'h1;
			if (s.od.slot == `PWD_OD_DUTY_FULL)
				s_nxt.od.act = s_nxt.od.cfg;
		end else begin
			s_nxt.od.slot_cnt = s.od.slot_cnt + 10'h001;
		end
		// enable acts at once so that turning off is immediate
		s_nxt.od.oe = s_nxt.od.cfg[`PWD_OD_EN_BIT]
			&& (s_nxt.od.slot <= s_nxt.od.act[`PWD_OD_DUTY_LSB +: 4]);
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			s <= '0;
		else
			s <= s_nxt;
	end

	assign reg_rdata = s.rdata;
	assign pulse_drv_o = 1'b0;
	assign pulse_drv_oe = s.od.oe;
	assign push_pull_out_a = s.pp[0].out;
	assign push_pull_out_b = s.pp[1].out;

	sequence pwd_od_write;
		reg_req.wr && reg_req.addr == `PWD_ADDR_OD;
	endsequence

	sequence pwd_pp_wrap;
		s.tick && s.pp[0].cnt >= pwd_pp_len(s.pp[0].act) - 18'h00001;
	endsequence

	sequence pwd_od_wrap;
		s.od.slot == `PWD_OD_DUTY_FULL && s.od.slot_cnt >= pwd_od_slot(s.od.act[`PWD_OD_FREQ_LSB +: 3]) - 10'h001;
	endsequence

	a_od_disabled_off: assert property (
		!s.od.cfg[`PWD_OD_EN_BIT] && !reg_req.wr |=> !pulse_drv_oe)
		else $error("open-drain output active while disabled");

	a_od_byte_store: assert property (pwd_od_write |=> s.od.cfg == $past(reg_req.wdata))
		else $error("open-drain control byte not stored");

	a_od_step_len: assert property (
		s.od.slot_cnt < pwd_od_slot(s.od.act[`PWD_OD_FREQ_LSB +: 3]))
		else $error("open-drain duty step too long");

	a_od_full_duty: assert property (
		(s.od.cfg[`PWD_OD_EN_BIT] && s.od.act[3:0] == `PWD_OD_DUTY_FULL && !reg_req.wr) ##1 !reg_req.wr
		|-> pulse_drv_oe [*2])
		else $error("full duty output not held active");

	a_pp_reset_zero: assert property (
		$rose(rstn) |-> s.pp[0].cfg == `PWD_CTL_RESET && s.pp[1].cfg == `PWD_CTL_RESET && !push_pull_out_a)
		else $error("push-pull not cleared by reset");

	a_pp_period_bound: assert property (
		!s.pp[0].act[`PWD_PP_MODE_BIT] |-> s.pp[0].cnt < 18'(`PWD_PERIOD_US))
		else $error("single-pulse period overrun");

	a_pp_always_on: assert property (
		s.pp[0].act == {1'b0, `PWD_SET_ALWAYS_ON} |-> push_pull_out_a)
		else $error("always-on setting not on");

	a_pp_pulse_end: assert property (
		!s.pp[0].act[7] && s.pp[0].act[6:0] != `PWD_SET_ALWAYS_ON && s.pp[0].cnt >= pwd_pp_on(s.pp[0].act)
		|-> !push_pull_out_a)
		else $error("single pulse too long");

	a_pp_timed_on: assert property (
		s.pp[1].act[`PWD_PP_MODE_BIT] |-> push_pull_out_b == (s.pp[1].cnt < pwd_pp_on(s.pp[1].act)))
		else $error("timed mode on phase wrong");

	// a setting may move into the active copy only at a period wrap
	a_pp_latch_hold: assert property (
		!(s.tick && s.pp[0].cnt >= pwd_pp_len(s.pp[0].act) - 18'h00001) |=> $stable(s.pp[0].act))
		else $error("setting applied mid-period");

	a_pp_latch_take: assert property (pwd_pp_wrap |=> s.pp[0].act == s.pp[0].cfg)
		else $error("setting not applied at period wrap");

	a_od_latch_hold: assert property (
		!(s.od.slot == `PWD_OD_DUTY_FULL
			&& s.od.slot_cnt >= pwd_od_slot(s.od.act[`PWD_OD_FREQ_LSB +: 3]) - 10'h001) |=> $stable(s.od.act))
		else $error("open-drain setting applied mid-period");

	a_od_latch_take: assert property (pwd_od_wrap |=> s.od.act == s.od.cfg)
		else $error("open-drain setting not applied at period wrap");

	a_tick_align: assert property (s.tick |-> s.tick_cnt == 12'h000)
		else $error("time base tick misaligned");

	a_od_quick_off: assert property (pwd_od_write ##0 !reg_req.wdata[`PWD_OD_EN_BIT] |=> !pulse_drv_oe)
		else $error("open-drain output not stopped by disable");

	a_od_low_phase: assert property (
		s.od.slot > s.od.act[`PWD_OD_DUTY_LSB +: 4] |-> !pulse_drv_oe)
		else $error("open-drain active past its duty steps");

	a_pp_same_setting: assert property (
		s.pp[0].act == s.pp[1].act && s.pp[0].cnt == s.pp[1].cnt |-> push_pull_out_a == push_pull_out_b)
		else $error("push-pull outputs differ for equal settings");

	a_pp_b_bound: assert property (
		!s.pp[1].act[`PWD_PP_MODE_BIT] |-> s.pp[1].cnt < 18'(`PWD_PERIOD_US))
		else $error("second single-pulse period overrun");

	a_pp_b_steady: assert property (
		s.pp[1].act == {1'b0, `PWD_SET_ALWAYS_ON} |-> push_pull_out_b)
		else $error("second always-on setting not on");

	a_reg_read_back: assert property (
		reg_req.rd && reg_req.addr == `PWD_ADDR_OD |=> reg_rdata == $past(s.od.cfg))
		else $error("read data does not match stored byte");

endmodule : pwd_pulse_drivers

// file: testbench/pwd_load_model.sv
// load on one output pin: measures the last active time and the last period in clock cycles
module pwd_load_model (
	// clock
	input wire logic sys_clk,
	// load drive level, high while the load is energised
	input wire logic load_on,
	// measurements
	output logic [31:0] hi_len,
	output logic [31:0] per_len
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_r = 1'b0;
	logic [31:0] hi_cnt_r = '0;
	logic [31:0] per_cnt_r = '0;
	always_ff @(posedge sys_clk) begin
		last_r <= load_on;
		hi_cnt_r <= load_on ? hi_cnt_r + 32'h1 : 32'h0;
		per_cnt_r <= (load_on && !last_r) ? 32'h1 : per_cnt_r + 32'h1;
		if (!load_on && last_r) hi_len <= hi_cnt_r;
		if (load_on && !last_r) per_len <= per_cnt_r;
	end
endmodule : pwd_load_model

// file: testbench/tb_top.sv
`include "pwd_regs.svh"
module tb_top;
	import pwd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	pwd_reg_req_s reg_req = '0;
	logic [7:0] reg_rdata;
	logic od_o, od_oe, pp_a, pp_b;
	// open-drain pin with pull-up; the load is on while the pin is sunk
	wire od_wire = od_oe ? od_o : 1'b1;
	logic [31:0] a_hi, a_per, b_hi, b_per, d_hi, d_per;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	pwd_pulse_drivers #(.TICK_CYCLES(1)) i_pwd_pulse_drivers (.sys_clk(sys_clk), .rstn(rstn),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .pulse_drv_o(od_o), .pulse_drv_oe(od_oe),
		.push_pull_out_a(pp_a), .push_pull_out_b(pp_b));
	pwd_load_model i_pwd_load_model_a (.sys_clk(sys_clk), .load_on(pp_a), .hi_len(a_hi), .per_len(a_per));
	pwd_load_model i_pwd_load_model_b (.sys_clk(sys_clk), .load_on(pp_b), .hi_len(b_hi), .per_len(b_per));
	pwd_load_model i_pwd_load_model_d (.sys_clk(sys_clk), .load_on(!od_wire), .hi_len(d_hi), .per_len(d_per));
	initial forever #50 sys_clk = ~sys_clk;
	task automatic print_verdict();
		if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		@(negedge sys_clk);
		reg_req.wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(negedge sys_clk);
		reg_req.rd = 1'b0;
		@(negedge sys_clk);
		check("reg_rdata", {24'h0, reg_rdata}, {24'h0, exp});
	endtask : rd
	task automatic waitc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : waitc
	// cuts a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 90000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		waitc(5);
		rstn = 1'b1;
		for (int i = 0; i < 3; i++) rd(8'h5a + 8'(i), 8'h00);
		rd(8'h5d, 8'h00);
		wr(`PWD_ADDR_OD, 8'h80);
		wr(`PWD_ADDR_PP_A, 8'h20);
		wr(`PWD_ADDR_PP_B, 8'h7f);
		rd(`PWD_ADDR_OD, 8'h80);
		rd(`PWD_ADDR_PP_B, 8'h7f);
		waitc(12000);
		check("od_hi", d_hi, 32'd27);
		check("od_per", d_per, 32'd432);
		check("a_hi", a_hi, 32'd1000);
		check("a_per", a_per, 32'd4000);
		check("b_on", {31'h0, pp_b}, 32'h1);
		wr(`PWD_ADDR_OD, 8'he7);
		wr(`PWD_ADDR_PP_A, 8'h7e);
		wr(`PWD_ADDR_PP_B, 8'hb8);
		waitc(20000);
		check("od_hi", d_hi, 32'd3336);
		check("od_per", d_per, 32'd6672);
		check("a_hi", a_hi, 32'd3937);
		check("b_hi", b_hi, 32'd244);
		check("b_per", b_per, 32'd734);
		wr(`PWD_ADDR_OD, 8'h8f);
		waitc(7000);
		check("od_full", {31'h0, od_oe}, 32'h1);
		wr(`PWD_ADDR_OD, 8'h0f);
		waitc(2);
		check("od_off", {31'h0, od_oe}, 32'h0);
		waitc(1000);
		check("od_idle", {31'h0, od_oe}, 32'h0);
		wr(`PWD_ADDR_PP_A, 8'hc0);
		wr(`PWD_ADDR_PP_B, 8'hc0);
		waitc(10000);
		check("a_hi", a_hi, 32'd5000);
		check("b_hi", b_hi, 32'd5000);
		// mid-run reset clears every byte and output
		rstn = 1'b0;
		waitc(2);
		rstn = 1'b1;
		check("rst_out", {29'h0, pp_a, pp_b, od_oe}, 32'h0);
		for (int i = 0; i < 3; i++) rd(8'h5a + 8'(i), `PWD_CTL_RESET);
		print_verdict();
	end
endmodule : tb_top
